//--- pkg/touch_i2c_pkg.sv
// constants and types shared by both ends of the touch i2c link
// assumes a 10 MHz host clock; the device runs on a clock of its own
package touch_i2c_pkg;
   // 7-bit target addresses: 0xba/0xbb and 0x28/0x29 on the wire
   localparam logic [6:0]  ADDR_PRI      = 7'h5d;
   localparam logic [6:0]  ADDR_ALT      = 7'h14;
   // write-only real-time command register
   localparam logic [15:0] CMD_REG       = 16'h8040;
   localparam logic [7:0]  CMD_READ_VAL  = 8'h00;
   // host clock and link timing
   localparam int          CLK_NS        = 100;
   localparam int          QUARTER_NS    = 625;
   localparam int          QUARTER_CYC   = (QUARTER_NS + CLK_NS - 1) / CLK_NS;
   localparam int          RST_LOW_NS    = 100000;
   localparam int          RST_LOW_CYC   = (RST_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int          SEL_HOLD_NS   = 100000;
   localparam int          SEL_HOLD_CYC  = (SEL_HOLD_NS + CLK_NS - 1) / CLK_NS;
   // host register offsets
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_REGADDR   = 8'h04;
   localparam logic [7:0]  OFS_LEN       = 8'h08;
   localparam logic [7:0]  OFS_DATA      = 8'h0c;
   localparam logic [7:0]  OFS_STATUS    = 8'h10;
   // control and status bit positions
   localparam int          CTRL_GO       = 0;
   localparam int          CTRL_READ     = 1;
   localparam int          CTRL_ALT      = 2;
   localparam int          CTRL_PWRUP    = 3;
   localparam int          STAT_BUSY     = 0;
   localparam int          STAT_NACK     = 1;
   // reset values
   localparam logic [15:0] REGADDR_RST   = 16'h0000;
   localparam logic [1:0]  LEN_RST       = 2'h0;
   localparam logic [31:0] DATA_RST      = 32'h0000_0000;
   typedef enum logic [2:0] {
      D_IDLE, D_ADDR, D_PTR_HI, D_PTR_LO, D_WRITE, D_READ
   } dev_state_t;
   typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} host_state_t;
   typedef enum logic [1:0] {P_IDLE, P_RESET, P_HOLD} pwrup_state_t;
endpackage

//--- pkg/touch_i2c_if.sv
// link wires between the host i2c master and the touch controller
// sda is open drain with a pull-up; int is push-pull from either side
`timescale 1ns/100ps
`default_nettype none
interface touch_i2c_if;
   logic scl;
   logic trst_n;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic host_int_o;
   logic host_int_oe;
   logic dev_int_o;
   logic dev_int_oe;
   logic sda;
   logic int_line;
   // wired-and with pull-up
   assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
   // host wins during power-up strapping; idle level is high
   assign int_line = host_int_oe ? host_int_o : (dev_int_oe ? dev_int_o : 1'b1);
   modport host (output scl, trst_n, host_sda_o, host_sda_oe, host_int_o, host_int_oe,
                 input sda, int_line);
   modport device (input scl, trst_n, sda, int_line,
                   output dev_sda_o, dev_sda_oe, dev_int_o, dev_int_oe);
endinterface
`default_nettype wire

//--- core/touch_i2c_sync.sv
// two-flop synchroniser for pin inputs
// assumes inputs are quasi-static levels relative to clk
`timescale 1ns/100ps
`default_nettype none
module touch_i2c_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // async in, synced out
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;
   // first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= RST_VAL;
         q    <= RST_VAL;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule
`default_nettype wire

//--- core/touch_i2c_device.sv
// touch controller i2c target with byte register space
// assumes dev_clk oversamples scl by at least eight
`timescale 1ns/100ps
`default_nettype none
module touch_i2c_device #(
   parameter int MEM_AW = 8
) (
   // own clock and power-on reset
   input  wire logic              dev_clk,
   input  wire logic              dev_rst_n,
   // link
   touch_i2c_if.device            link,
   // touch core side
   input  wire logic              touch_event,
   input  wire logic              usr_wr,
   input  wire logic [MEM_AW-1:0] usr_addr,
   input  wire logic [7:0]        usr_data,
   output logic                   cmd_valid,
   output logic [7:0]             cmd_code,
   output logic                   addr_alt
);
   logic                     scl_s;
   logic                     sda_s;
   logic                     trst_s;
   logic                     int_s;
   logic                     scl_q;
   logic                     sda_q;
   logic                     trst_q;
   logic                     strapped;
   logic                     start_c;
   logic                     stop_c;
   logic                     rise;
   logic                     fall;
   logic                     wr_hit;
   logic [6:0]               slave_addr;
   logic [7:0]               rd_byte;
   logic [7:0]               shreg;
   logic [3:0]               bitcnt;
   logic [15:0]              ptr;
   logic [7:0]               mem [2**MEM_AW];
   touch_i2c_pkg::dev_state_t state;

   // pins cross into dev_clk here
   touch_i2c_sync #(
      .WIDTH   (4),
      .RST_VAL (4'hf)
   ) u_sync (
      .clk   (dev_clk),
      .rst_n (dev_rst_n),
      .d     ({link.scl, link.sda, link.trst_n, link.int_line}),
      .q     ({scl_s, sda_s, trst_s, int_s})
   );

   // previous sampled levels for edge detection
   always_ff @(posedge dev_clk or negedge dev_rst_n) begin
      if (!dev_rst_n) begin
         scl_q  <= 1'b1;
         sda_q  <= 1'b1;
         trst_q <= 1'b1;
      end else begin
         scl_q  <= scl_s;
         sda_q  <= sda_s;
         trst_q <= trst_s;
      end
   end

   assign start_c = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_c  = scl_s & scl_q & ~sda_q & sda_s;
   assign rise    = scl_s & ~scl_q;
   assign fall    = ~scl_s & scl_q;

   always_ff @(posedge dev_clk or negedge dev_rst_n) begin
      if (!dev_rst_n) begin
         addr_alt <= 1'b0;
         strapped <= 1'b0;
      end else if (trst_s && !trst_q) begin
         addr_alt <= int_s;
         strapped <= 1'b1;
      end
   end

   assign slave_addr = addr_alt ? touch_i2c_pkg::ADDR_ALT : touch_i2c_pkg::ADDR_PRI;

   // command register reads back as a fixed value
   assign rd_byte = (ptr == touch_i2c_pkg::CMD_REG) ? touch_i2c_pkg::CMD_READ_VAL
                                                    : mem[ptr[MEM_AW-1:0]];
   // data byte complete at the falling edge that opens its ack clock
   assign wr_hit  = fall && (bitcnt == 4'd8) && (state == touch_i2c_pkg::D_WRITE);

   // protocol engine; never drives scl and never opens a transfer
   // target-only engine
   always_ff @(posedge dev_clk or negedge dev_rst_n) begin
      if (!dev_rst_n) begin
         state           <= touch_i2c_pkg::D_IDLE;
         bitcnt          <= 4'h0;
         shreg           <= 8'h00;
         ptr             <= 16'h0000;
         link.dev_sda_oe <= 1'b0;
      end else if (start_c) begin
         // repeated start also lands here, pointer kept
         state           <= touch_i2c_pkg::D_ADDR;
         bitcnt          <= 4'h0;
         link.dev_sda_oe <= 1'b0;
      end else if (stop_c) begin
         state           <= touch_i2c_pkg::D_IDLE;
         link.dev_sda_oe <= 1'b0;
      end else if (state != touch_i2c_pkg::D_IDLE) begin
         if (rise) begin
            if (bitcnt < 4'd8) begin
               bitcnt <= bitcnt + 4'd1;
               if (state != touch_i2c_pkg::D_READ) begin
                  shreg <= {shreg[6:0], sda_s};
               end
            end else if (state == touch_i2c_pkg::D_READ && bitcnt == 4'd8) begin
               if (sda_s) begin
                  state <= touch_i2c_pkg::D_IDLE;
               end else begin
                  bitcnt <= 4'd9;
               end
            end
         end else if (fall) begin
            // sda only moves on scl falling edges
            if (state == touch_i2c_pkg::D_READ) begin
               if (bitcnt == 4'd9) begin
                  shreg           <= rd_byte;
                  link.dev_sda_oe <= ~rd_byte[7];
                  ptr             <= ptr + 16'h0001;
                  bitcnt          <= 4'h0;
               end else if (bitcnt == 4'd8) begin
                  link.dev_sda_oe <= 1'b0; // master owns ack clock
               end else if (bitcnt != 4'h0) begin
                  link.dev_sda_oe <= ~shreg[3'(7 - bitcnt)];
               end
            end else if (bitcnt == 4'd8) begin
               bitcnt          <= 4'd9;
               link.dev_sda_oe <= 1'b1;
               case (state)
                  touch_i2c_pkg::D_ADDR: begin
                     // mismatch: no ack, wait for start
                     if (shreg[7:1] != slave_addr) begin
                        state           <= touch_i2c_pkg::D_IDLE;
                        link.dev_sda_oe <= 1'b0;
                     end else if (shreg[0]) begin
                        state <= touch_i2c_pkg::D_READ;
                     end else begin
                        state <= touch_i2c_pkg::D_PTR_HI;
                     end
                  end
                  touch_i2c_pkg::D_PTR_HI: begin
                     ptr[15:8] <= shreg;
                     state     <= touch_i2c_pkg::D_PTR_LO;
                  end
                  touch_i2c_pkg::D_PTR_LO: begin
                     ptr[7:0] <= shreg;
                     state    <= touch_i2c_pkg::D_WRITE;
                  end
                  default: begin
                     ptr <= ptr + 16'h0001;
                  end
               endcase
            end else if (bitcnt == 4'd9) begin
               // ack clock over, release and take next byte
               link.dev_sda_oe <= 1'b0;
               bitcnt          <= 4'h0;
            end
         end
      end
   end

   // register array; no reset, contents are data not control
   always_ff @(posedge dev_clk) begin
      if (wr_hit && ptr != touch_i2c_pkg::CMD_REG) begin
         mem[ptr[MEM_AW-1:0]] <= shreg;
      end else if (usr_wr) begin
         mem[usr_addr] <= usr_data;
      end
   end

   // command write becomes a strobe, not storage
   always_ff @(posedge dev_clk or negedge dev_rst_n) begin
      if (!dev_rst_n) begin
         cmd_valid <= 1'b0;
         cmd_code  <= 8'h00;
      end else begin
         cmd_valid <= wr_hit && (ptr == touch_i2c_pkg::CMD_REG);
         if (wr_hit && ptr == touch_i2c_pkg::CMD_REG) begin
            cmd_code <= shreg;
         end
      end
   end

   // event pin only after strapping, so the strap is never disturbed
   always_ff @(posedge dev_clk or negedge dev_rst_n) begin
      if (!dev_rst_n) begin
         link.dev_int_oe <= 1'b0;
         link.dev_int_o  <= 1'b1;
         link.dev_sda_o  <= 1'b0;
      end else begin
         link.dev_int_oe <= strapped & trst_s & touch_event;
         link.dev_int_o  <= 1'b0;
         link.dev_sda_o  <= 1'b0; // open drain: low whenever enabled
      end
   end
endmodule
`default_nettype wire

//--- core/touch_i2c_host.sv
// host i2c master with ahb-lite register port
// assumes hclk at 10 MHz; scl is divided down from it
`timescale 1ns/100ps
`default_nettype none
module touch_i2c_host #(
   parameter int QUARTER = touch_i2c_pkg::QUARTER_CYC,
   parameter int RST_LOW = touch_i2c_pkg::RST_LOW_CYC,
   parameter int SEL_HLD = touch_i2c_pkg::SEL_HOLD_CYC
) (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // link
   touch_i2c_if.host        link
);
   logic                         sda_s;
   logic                         wr_pend;
   logic [7:0]                   wa;
   logic                         alt;
   logic                         rd_mode;
   logic                         nack;
   logic [15:0]                  reg_addr;
   logic [1:0]                   lenm1;
   logic [31:0]                  data;
   logic [15:0]                  qcnt;
   logic [1:0]                   q;
   logic [3:0]                   bitn;
   logic [2:0]                   idx;
   logic [7:0]                   rxsh;
   logic [7:0]                   txb;
   logic [15:0]                  pcnt;
   logic                         go;
   logic                         tick;
   logic                         rx;
   logic                         last;
   logic [2:0]                   last_wr;
   logic [2:0]                   last_rd;
   touch_i2c_pkg::host_state_t   hst;
   touch_i2c_pkg::pwrup_state_t  pst;

   touch_i2c_sync #(
      .WIDTH   (1),
      .RST_VAL (1'b1)
   ) u_sync (
      .clk   (hclk),
      .rst_n (hresetn),
      .d     (link.sda),
      .q     (sda_s)
   );

   // address phase captured, zero wait states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend   <= 1'b0;
         wa        <= 8'h00;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wr_pend <= hsel & htrans[1] & hready & hwrite;
         wa      <= haddr[7:0];
         if (hsel && htrans[1] && hready && !hwrite) begin
            if (haddr[7:0] == touch_i2c_pkg::OFS_CTRL) begin
               hrdata <= {29'h0, alt, rd_mode, 1'b0};
            end else if (haddr[7:0] == touch_i2c_pkg::OFS_REGADDR) begin
               hrdata <= {16'h0000, reg_addr};
            end else if (haddr[7:0] == touch_i2c_pkg::OFS_LEN) begin
               hrdata <= {30'h0, lenm1};
            end else if (haddr[7:0] == touch_i2c_pkg::OFS_DATA) begin
               hrdata <= data;
            end else if (haddr[7:0] == touch_i2c_pkg::OFS_STATUS) begin
               hrdata <= {30'h0, nack, (hst != touch_i2c_pkg::H_IDLE) || (pst != touch_i2c_pkg::P_IDLE)};
            end else begin
               hrdata <= 32'h0000_0000; // unmapped reads zero
            end
         end
      end
   end

   // go ignored while busy; hsize is always a word here
   assign go = wr_pend && wa == touch_i2c_pkg::OFS_CTRL && hwdata[touch_i2c_pkg::CTRL_GO]
               && hst == touch_i2c_pkg::H_IDLE && pst == touch_i2c_pkg::P_IDLE;

   // setup registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         alt      <= 1'b0;
         rd_mode  <= 1'b0;
         reg_addr <= touch_i2c_pkg::REGADDR_RST;
         lenm1    <= touch_i2c_pkg::LEN_RST;
      end else if (wr_pend && hst == touch_i2c_pkg::H_IDLE) begin
         if (wa == touch_i2c_pkg::OFS_CTRL) begin
            alt     <= hwdata[touch_i2c_pkg::CTRL_ALT];
            rd_mode <= hwdata[touch_i2c_pkg::CTRL_READ];
         end else if (wa == touch_i2c_pkg::OFS_REGADDR) begin
            reg_addr <= hwdata[15:0];
         end else if (wa == touch_i2c_pkg::OFS_LEN) begin
            lenm1 <= hwdata[1:0];
         end
      end
   end

   assign tick    = qcnt == 16'(QUARTER - 1);
   assign rx      = rd_mode && idx >= 3'd4;
   assign last_wr = 3'(3'd3 + {1'b0, lenm1});
   assign last_rd = 3'(3'd4 + {1'b0, lenm1});
   assign last    = rd_mode ? idx == last_rd : idx == last_wr;
   // byte sequence: write address, pointer high, pointer low, data or read address
   always_comb begin
      txb = data[{2'(idx - 3'd3), 3'b000} +: 8];
      if (idx == 3'd0) begin
         txb = {alt ? touch_i2c_pkg::ADDR_ALT : touch_i2c_pkg::ADDR_PRI, 1'b0};
      end else if (idx == 3'd1) begin
         txb = reg_addr[15:8];
      end else if (idx == 3'd2) begin
         txb = reg_addr[7:0];
      end else if (rd_mode) begin
         txb = {alt ? touch_i2c_pkg::ADDR_ALT : touch_i2c_pkg::ADDR_PRI, 1'b1};
      end
   end

   // received bytes land in data; software may also load it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data <= touch_i2c_pkg::DATA_RST;
      end else if (tick && hst == touch_i2c_pkg::H_BYTE && q == 2'd3 && bitn == 4'd8 && rx) begin
         data[{idx[1:0], 3'b000} +: 8] <= rxsh;
      end else if (wr_pend && wa == touch_i2c_pkg::OFS_DATA && hst == touch_i2c_pkg::H_IDLE) begin
         data <= hwdata;
      end
   end

   // bit engine: four quarters per scl period
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hst              <= touch_i2c_pkg::H_IDLE;
         qcnt             <= 16'h0000;
         q                <= 2'd0;
         bitn             <= 4'h0;
         idx              <= 3'd0;
         rxsh             <= 8'h00;
         nack             <= 1'b0;
         link.scl         <= 1'b1;
         link.host_sda_oe <= 1'b0;
         link.host_sda_o  <= 1'b0;
      end else if (go) begin
         hst  <= touch_i2c_pkg::H_START;
         qcnt <= 16'h0000;
         q    <= 2'd0;
         idx  <= 3'd0;
         nack <= 1'b0;
      end else if (hst != touch_i2c_pkg::H_IDLE) begin
         qcnt <= tick ? 16'h0000 : qcnt + 16'h0001;
         if (tick) begin
            q <= q + 2'd1;
            case (hst)
               touch_i2c_pkg::H_START: begin
                  if (q == 2'd0) link.host_sda_oe <= 1'b0;
                  if (q == 2'd1) link.scl <= 1'b1;
                  if (q == 2'd2) link.host_sda_oe <= 1'b1; // falls with scl high
                  if (q == 2'd3) begin
                     link.scl <= 1'b0;
                     bitn     <= 4'h0;
                     hst      <= touch_i2c_pkg::H_BYTE;
                  end
               end
               touch_i2c_pkg::H_BYTE: begin
                  if (q == 2'd0) begin
                     if (bitn < 4'd8) link.host_sda_oe <= rx ? 1'b0 : ~txb[3'(7 - bitn)];
                     else link.host_sda_oe <= rx & ~last; // nack the final byte
                  end
                  if (q == 2'd1) link.scl <= 1'b1;
                  if (q == 2'd2 && bitn < 4'd8) rxsh <= {rxsh[6:0], sda_s};
                  if (q == 2'd2 && bitn == 4'd8 && !rx && sda_s) nack <= 1'b1;
                  if (q == 2'd3) begin
                     link.scl <= 1'b0;
                     bitn     <= bitn + 4'd1;
                     if (bitn == 4'd8) begin
                        bitn <= 4'h0;
                        if ((!rx && sda_s) || last) begin
                           hst <= touch_i2c_pkg::H_STOP;
                        end else begin
                           idx <= idx + 3'd1;
                           if (rd_mode && idx == 3'd2) hst <= touch_i2c_pkg::H_START;
                        end
                     end
                  end
               end
               touch_i2c_pkg::H_STOP: begin
                  if (q == 2'd0) link.host_sda_oe <= 1'b1;
                  if (q == 2'd1) link.scl <= 1'b1;
                  if (q == 2'd2) link.host_sda_oe <= 1'b0; // rises with scl high
                  if (q == 2'd3) hst <= touch_i2c_pkg::H_IDLE;
               end
               default: hst <= touch_i2c_pkg::H_IDLE;
            endcase
         end
      end
   end

   // power-up strap: hold reset low with int set, release reset, then int
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pst              <= touch_i2c_pkg::P_IDLE;
         pcnt             <= 16'h0000;
         link.trst_n      <= 1'b1;
         link.host_int_oe <= 1'b0;
         link.host_int_o  <= 1'b0;
      end else begin
         case (pst)
            touch_i2c_pkg::P_IDLE: begin
               if (wr_pend && wa == touch_i2c_pkg::OFS_CTRL && hwdata[touch_i2c_pkg::CTRL_PWRUP]
                   && hst == touch_i2c_pkg::H_IDLE) begin
                  pst              <= touch_i2c_pkg::P_RESET;
                  pcnt             <= 16'h0000;
                  link.trst_n      <= 1'b0;
                  link.host_int_oe <= 1'b1;
                  link.host_int_o  <= hwdata[touch_i2c_pkg::CTRL_ALT];
               end
            end
            touch_i2c_pkg::P_RESET: begin
               pcnt <= pcnt + 16'h0001;
               if (pcnt == 16'(RST_LOW - 1)) begin
                  pst         <= touch_i2c_pkg::P_HOLD;
                  pcnt        <= 16'h0000;
                  link.trst_n <= 1'b1;
               end
            end
            default: begin
               pcnt <= pcnt + 16'h0001;
               if (pcnt == 16'(SEL_HLD - 1)) begin
                  pst              <= touch_i2c_pkg::P_IDLE;
                  link.host_int_oe <= 1'b0;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

//--- bench/touch_i2c_checker.sv
// link wire checks sampled on the host clock
// assumes QUARTER of 7 and strap counts of 20 from the bench
`timescale 1ns/100ps
`default_nettype none
module touch_i2c_checker (
   // host domain
   input wire logic hclk,
   input wire logic hresetn,
   // link wires
   input wire logic scl,
   input wire logic sda,
   input wire logic trst_n,
   input wire logic host_sda_o,
   input wire logic host_sda_oe,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic host_int_oe
);
   logic sda_q;
   logic frame;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // frame tracker: device drive outside a frame is a fault
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sda_q <= 1'b1;
         frame <= 1'b0;
      end else begin
         sda_q <= sda;
         if (scl && sda_q != sda) frame <= sda_q;
      end
   end
   sequence strap_low_s;
      !trst_n && host_int_oe;
   endsequence
   a_dev_sda_stable: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("device sda moved while scl high");
   a_dev_take_low: assert property ($rose(dev_sda_oe) |-> !scl)
      else $error("device took sda with scl high");
   a_dev_open_drain: assert property (dev_sda_oe |-> !dev_sda_o)
      else $error("device drives sda high");
   a_host_open_drain: assert property (host_sda_oe |-> !host_sda_o)
      else $error("host drives sda high");
   a_start_by_host: assert property (scl && sda_q && !sda |-> host_sda_oe)
      else $error("start not made by host");
   a_dev_in_frame: assert property (dev_sda_oe |-> frame)
      else $error("device drove sda outside a frame");
   a_scl_low_hold: assert property ($fell(scl) |=> !scl [*8])
      else $error("scl low period short");
   a_scl_high_hold: assert property ($rose(scl) |=> scl [*6])
      else $error("scl high period short");
   a_strap_low: assert property ($fell(trst_n) |=> strap_low_s [*8])
      else $error("strap not held in reset");
   a_strap_release: assert property ($rose(trst_n) |-> host_int_oe)
      else $error("int released at reset rise");
endmodule
`default_nettype wire

//--- bench/touch_i2c_register_slave_tb.sv
// bench joining host and touch device over one link
// assumes host register map from the package
`timescale 1ns/100ps
`default_nettype none
module touch_i2c_register_slave_tb;
   logic        hclk = 1'b0;
   logic        dev_clk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [2:0]  hsize = 3'h0;
   logic        touch_event = 1'b0;
   logic        hreadyout, hresp, cmd_valid, addr_alt;
   logic [31:0] hrdata, d;
   logic [7:0]  cmd_code;
   int          bad_count = 0, compares = 0, cmd_n = 0;
   touch_i2c_if link_if ();
   always #50 hclk = ~hclk;
   always #15 dev_clk = ~dev_clk;
   // command pulses counted on the device clock
   always @(posedge dev_clk) if (cmd_valid === 1'b1) cmd_n++;
   touch_i2c_host #(.RST_LOW(20), .SEL_HLD(20)) touch_i2c_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(link_if));
   touch_i2c_device touch_i2c_device_inst (.dev_clk(dev_clk), .dev_rst_n(hresetn), .link(link_if),
      .touch_event(touch_event), .usr_wr(1'b0), .usr_addr(8'h0), .usr_data(8'h0), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .addr_alt(addr_alt));
   touch_i2c_checker touch_i2c_checker_inst (.hclk(hclk), .hresetn(hresetn), .scl(link_if.scl), .sda(link_if.sda),
      .trst_n(link_if.trst_n), .host_sda_o(link_if.host_sda_o), .host_sda_oe(link_if.host_sda_oe),
      .dev_sda_o(link_if.dev_sda_o), .dev_sda_oe(link_if.dev_sda_oe), .host_int_oe(link_if.host_int_oe));
   task results;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // bounded wait for hready at a rising edge
   task waitrdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         bad_count++;
         results();
      end
   endtask
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      hsize <= 3'h2;
      htrans <= 2'h2;
      waitrdy();
      htrans <= 2'h0;
      hwdata <= wd;
      waitrdy();
      d = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask
   // launch and poll busy; status left in d
   task run(input logic [7:0] c);
      int n;
      xfer(1'b1, touch_i2c_pkg::OFS_CTRL, {24'h0, c});
      repeat (4) @(posedge hclk);
      n = 0;
      do begin
         xfer(1'b0, touch_i2c_pkg::OFS_STATUS, 32'h0);
         n++;
      end while (d[0] !== 1'b0 && n < 3000);
      if (n >= 3000) begin
         bad_count++;
         results();
      end
   endtask
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(1'b0, touch_i2c_pkg::OFS_STATUS, 32'h0);
      chk(d, 32'h0);
      run(8'h0c);
      repeat (45) @(posedge hclk);
      chk({31'h0, addr_alt}, 32'h1);
      touch_event <= 1'b1;
      repeat (3) @(posedge hclk);
      chk({31'h0, link_if.int_line}, 32'h0);
      touch_event <= 1'b0;
      repeat (3) @(posedge hclk);
      chk({31'h0, link_if.int_line}, 32'h1);
      xfer(1'b1, touch_i2c_pkg::OFS_REGADDR, 32'h10);
      xfer(1'b1, touch_i2c_pkg::OFS_LEN, 32'h3);
      xfer(1'b1, touch_i2c_pkg::OFS_DATA, 32'h44332211);
      run(8'h05);
      chk(d, 32'h0);
      xfer(1'b1, touch_i2c_pkg::OFS_DATA, 32'h0);
      run(8'h07);
      xfer(1'b0, touch_i2c_pkg::OFS_DATA, 32'h0);
      chk(d, 32'h44332211);
      xfer(1'b1, touch_i2c_pkg::OFS_REGADDR, 32'h8040);
      xfer(1'b1, touch_i2c_pkg::OFS_LEN, 32'h0);
      xfer(1'b1, touch_i2c_pkg::OFS_DATA, 32'ha5);
      run(8'h05);
      chk({24'h0, cmd_code}, 32'ha5);
      chk(cmd_n, 32'h1);
      run(8'h07);
      xfer(1'b0, touch_i2c_pkg::OFS_DATA, 32'h0);
      chk({24'h0, d[7:0]}, {24'h0, touch_i2c_pkg::CMD_READ_VAL});
      run(8'h01);
      chk(d, 32'h2);
      results();
   end
endmodule
`default_nettype wire
